// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import tmw_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mem_we, mem_we2;
  logic nv_enh_flag, nv_enh_clr, nv_lock_we, battery_mode;
  logic pwr_switch_en, por_req;
  logic [1:0] bresp, rresp;
  logic [2:0] nv_lock, lock_state, lock2;
  logic [3:0] wstrb;
  logic [7:0] awaddr, araddr, mem_wdata, status;
  logic [15:0] mem_addr;
  logic [31:0] wdata, rdata, s;
  logic [1:0] rs;
  logic [23:0] wq[$];
  int num_errors, n_compared, n_clr, n_mem2, n_lwe;
  tmw_link_if lnk();
  tmw_link_if lnk2();
  tmw_host tmw_host_inst(.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .lnk(lnk.host));
  tmw_device tmw_device_inst(.aclk(aclk), .aresetn(aresetn),
    .lnk(lnk.device), .nv_enh_flag(nv_enh_flag), .nv_lock(nv_lock),
    .nv_enh_clr(nv_enh_clr), .nv_lock_we(nv_lock_we),
    .lock_state(lock_state), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .battery_mode(battery_mode),
    .pwr_switch_en(pwr_switch_en), .por_req(por_req), .status(status));
  // Second device faces the bench so frames can be corrupted
  tmw_device tmw_device_inst2(.aclk(aclk), .aresetn(aresetn),
    .lnk(lnk2.device), .nv_enh_flag(nv_enh_flag), .nv_lock(nv_lock),
    .nv_enh_clr(), .nv_lock_we(), .lock_state(lock2), .mem_we(mem_we2),
    .mem_addr(), .mem_wdata(), .battery_mode(), .pwr_switch_en(),
    .por_req(), .status());
  tmw_link_chk tmw_link_chk_inst(.aclk(aclk), .aresetn(aresetn),
    .dl_valid(lnk.dl_valid), .dl_ready(lnk.dl_ready),
    .dl_data(lnk.dl_data), .dl_last(lnk.dl_last),
    .ul_valid(lnk.ul_valid), .ul_ready(lnk.ul_ready),
    .ul_data(lnk.ul_data), .ul_last(lnk.ul_last));
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(negedge aclk)
  begin
    if (mem_we === 1'b1)
      wq.push_back({mem_addr, mem_wdata});
    if (mem_we2 === 1'b1)
      n_mem2++;
    if (nv_enh_clr === 1'b1)
      n_clr++;
    if (nv_lock_we === 1'b1)
      n_lwe++;
  end
  task complete_run;
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s %0h %0h", $time, msg, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] crc(input logic [7:0] c,
                                     input logic [7:0] b);
    logic [7:0] v;
    v = c ^ b;
    for (int i = 0; i < 8; i++)
      v = v[7] ? ({v[6:0], 1'b0} ^ CRC8_POLY) : {v[6:0], 1'b0};
    return v;
  endfunction : crc
  // Returns at the falling edge where s is high, payload still settled
  task automatic hs(const ref logic s);
    @(negedge aclk);
    while (!s) @(negedge aclk);
  endtask : hs
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    hs(awready);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    hs(bvalid);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    hs(arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    hs(rvalid);
    d = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check(r, RESP_OKAY, "write response");
  endtask : wr
  task automatic rst;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check({battery_mode, pwr_switch_en, lock_state},
      {nv_enh_flag, !nv_enh_flag, nv_lock}, "power state");
    @(posedge aclk);
  endtask : rst
  task automatic req(input logic [3:0] code, input logic [2:0] n,
    input logic [15:0] a, input logic [31:0] d, input logic [7:0] p,
    input logic [7:0] exp);
    int k;
    wq.delete();
    wr(OFS_ADDR, {16'h0000, a});
    wr(OFS_WDATA, d);
    wr(OFS_PARAM, {24'h000000, p});
    wr(OFS_CTRL, {1'b1, 20'h00000, n, 4'h0, code});
    s = 32'h0;
    for (k = 0; k < 400 && s[1] !== 1'b1; k++)
      axi_rd(OFS_STATUS, s, rs);
    check(s[24:16], 9'h1FE, "response frame");
    check(s[15:8], exp, "status byte");
    check(status, exp, "device status");
    k = (code == CMD_WRITE_MEM && exp[3:0] == ST_OK) ? n : 0;
    check(wq.size(), k, "write count");
    foreach (wq[i])
      check(wq[i], {a + 16'(i), d[8*i +: 8]}, "written byte");
  endtask : req
  task automatic frm(input logic [7:0] b[$], input int mode,
                     input logic [7:0] exp, input int nw);
    logic [7:0] c;
    logic [7:0] r[3];
    logic lst;
    c = CRC8_INIT;
    n_mem2 = 0;
    foreach (b[j])
      c = crc(c, b[j]);
    if (mode != 0)
      b.push_back(c ^ ((mode == 2) ? 8'h01 : 8'h00));
    foreach (b[j])
    begin
      lnk2.dl_valid <= 1'b1;
      lnk2.dl_data <= b[j];
      lnk2.dl_last <= (j == b.size() - 1);
      hs(lnk2.dl_ready);
      @(posedge aclk);
    end
    lnk2.dl_valid <= 1'b0;
    lnk2.dl_data <= ~b[b.size() - 1];
    for (int i = 0; i < 3; i++)
    begin
      hs(lnk2.ul_valid);
      r[i] = lnk2.ul_data;
      lst = lnk2.ul_last;
      @(posedge aclk);
    end
    check({r[0], r[2], lst}, {PREAMBLE, crc(8'h00, r[1]), 1'b1},
      "uplink frame");
    check(r[1], exp, "fault status");
    check(n_mem2, nw, "fault writes");
  endtask : frm
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    complete_run;
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    {nv_enh_flag, nv_lock} = 4'h0;
    {lnk2.dl_valid, lnk2.dl_last, lnk2.dl_data} = 10'h000;
    lnk2.ul_ready = 1'b1;
    rst;
    req(CMD_REPEAT, 3'h1, 16'h0, 32'h0, 8'h00, 8'h00);
    req(CMD_WRITE_MEM, 3'h4, 16'h0100, 32'h44332211, 8'h00, 8'h50);
    req(CMD_REPEAT, 3'h1, 16'h0, 32'h0, 8'h00, 8'h50);
    req(4'h3, 3'h1, 16'h0, 32'h0, 8'h00, 8'h34);
    req(CMD_WRITE_PROT, 3'h1, 16'h0, 32'h0, 8'h33, 8'h60);
    check(lock_state, 3'h5, "locks set");
    req(CMD_WRITE_MEM, 3'h1, 16'h07FF, 32'h77, 8'h00, 8'h52);
    req(CMD_WRITE_MEM, 3'h4, 16'h080E, 32'h1, 8'h00, 8'h52);
    req(CMD_WRITE_MEM, 3'h2, 16'h080E, 32'hBBAA, 8'h00, 8'h50);
    req(CMD_WRITE_MEM, 3'h1, 16'h0820, 32'hCC, 8'h00, 8'h50);
    req(CMD_WRITE_PROT, 3'h1, 16'h0, 32'h0, 8'h00, 8'h60);
    req(CMD_WRITE_PROT, 3'h1, 16'h0, 32'h0, 8'h01, 8'h65);
    req(CMD_WRITE_PROT, 3'h1, 16'h0, 32'h0, 8'h40, 8'h65);
    check(lock_state, 3'h5, "locks kept");
    check(n_lwe, 2, "lock stores");
    axi_rd(8'h20, s, rs);
    check(s, 32'h0, "unmapped read data");
    check(rs, RESP_SLVERR, "unmapped read");
    axi_wr(8'h24, 32'h1, rs);
    check(rs, RESP_SLVERR, "unmapped write");
    wr(OFS_STATUS, 32'hFFFFFFFF);
    nv_enh_flag <= 1'b1;
    nv_lock <= 3'h2;
    rst;
    req(CMD_WRITE_MEM, 3'h1, 16'h0805, 32'h5, 8'h00, 8'h52);
    frm('{8'h5F, 8'h01, 8'h00, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5,
      8'h00}, 1, 8'h50, 6);
    req(CMD_LEAVE_ENH, 3'h1, 16'h0, 32'h0, 8'h00, 8'hA0);
    check(n_clr, 1, "flag clear pulses");
    check({pwr_switch_en, battery_mode, por_req}, 3'h5, "power");
    nv_enh_flag <= 1'b0;
    nv_lock <= 3'h0;
    rst;
    frm('{8'h5F, 8'h01, 8'h00, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'h00},
      1, 8'h53, 0);
    frm('{8'h5F, 8'h01, 8'h00, 8'h11, 8'h00}, 2, 8'h51, 0);
    frm('{8'hE1}, 0, 8'h51, 0);
    frm('{8'h5F, 8'h01, 8'h00, 8'h11, 8'h00}, 1, 8'h50, 1);
    frm('{8'hAD, 8'h00}, 0, 8'hA3, 0);
    frm('{8'h5E}, 0, 8'h54, 0);
    frm('{8'hE1}, 0, 8'h54, 0);
    frm('{8'h6A, 8'h33}, 2, 8'h61, 0);
    check(lock2, 3'h0, "locks after bad frame");
    complete_run;
  end
endmodule : tb_top

// *** tmw_device.sv ***
// Design decisions made here: the request frame checks, the lock test and the power-down sequence.
`timescale 1ns/1ps
module tmw_device
  import tmw_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to the base station
  tmw_link_if.device lnk,
  // Nonvolatile state and memory write port
  input wire logic nv_enh_flag,
  input wire logic [2:0] nv_lock,
  output logic nv_enh_clr,
  output logic nv_lock_we,
  output logic [2:0] lock_state,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  // Power management
  output logic battery_mode,
  output logic pwr_switch_en,
  output logic por_req,
  // Last status byte
  output logic [7:0] status
);

  typedef enum logic [2:0] {
    D_RX = 3'b000,
    D_EXEC = 3'b001,
    D_WRITE = 3'b010,
    D_RESP = 3'b011,
    D_POR = 3'b100
  } tmw_dev_state_type;

  typedef struct packed {
    tmw_dev_state_type st;
    logic [FRAME_DEPTH-1:0][7:0] fb;
    logic [7:0] cnt;
    logic ovf;
    logic [7:0] crc;
    logic crc_ok;
    logic [7:0] idx;
    logic [7:0] nwr;
    logic [15:0] addr;
    logic [7:0] status;
    logic [1:0] ul_idx;
    logic ul_valid;
    logic [7:0] ul_data;
    logic ul_last;
    logic [2:0] lock;
    logic enh;
    logic init_done;
    logic leave_pend;
    logic pwr_sw_en;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic nv_enh_clr;
    logic lock_we;
    logic por_req;
  } tmw_dev_regs_type;

  tmw_dev_regs_type r;
  tmw_dev_regs_type n;

  function automatic logic overlaps(input logic [15:0] a,
                                    input logic [15:0] l,
                                    input logic [15:0] base,
                                    input logic [15:0] last);
    overlaps = !(l < base || a > last);
  endfunction : overlaps

  assign lnk.dl_ready = (r.st == D_RX);
  assign lnk.ul_valid = r.ul_valid;
  assign lnk.ul_data = r.ul_data;
  assign lnk.ul_last = r.ul_last;
  assign nv_enh_clr = r.nv_enh_clr;
  assign nv_lock_we = r.lock_we;
  assign lock_state = r.lock;
  assign mem_we = r.mem_we;
  assign mem_addr = r.mem_addr;
  assign mem_wdata = r.mem_wdata;
  assign battery_mode = r.enh;
  assign pwr_switch_en = r.pwr_sw_en;
  assign por_req = r.por_req;
  assign status = r.status;

  always_comb
  begin
    logic [3:0] cmd;
    logic [4:0] ck;
    logic [7:0] ndata;
    logic [7:0] maxd;
    logic [7:0] pb;
    logic [15:0] waddr;
    logic [15:0] wlast;
    logic hit;
    logic pvalid;
    logic [2:0] newlock;
    cmd = r.fb[0][7:4];
    ck = check_nibble(cmd);
    ndata = r.cnt - WR_OVERHEAD;
    maxd = r.enh ? MAX_DATA_ENH : MAX_DATA_NORMAL;
    pb = r.fb[1];
    waddr = {r.fb[1], r.fb[2]};
    wlast = waddr + {8'h00, ndata} - 16'h0001;
    hit = 1'b0;
    pvalid = (pb[7:6] == 2'b00);
    newlock = 3'b000;
    for (int i = 0; i < 3; i++)
    begin
      hit = hit | (r.lock[i] &&
        overlaps(waddr, wlast, REGION_BASE[i], REGION_LAST[i]));
      pvalid = pvalid && (pb[2*i+:2] == LOCK_ON ||
        pb[2*i+:2] == LOCK_OFF);
      newlock[i] = (pb[2*i+:2] == LOCK_ON);
    end
    n = r;
    n.mem_we = 1'b0;
    n.nv_enh_clr = 1'b0;
    n.lock_we = 1'b0;
    // flag and locks caught after reset
    if (!r.init_done)
    begin
      n.init_done = 1'b1;
      n.enh = nv_enh_flag;
      n.pwr_sw_en = !nv_enh_flag;
      n.lock = nv_lock;
    end
    unique case (r.st)
      D_RX:
      begin
        if (lnk.dl_valid)
        begin
          if (r.cnt < FRAME_DEPTH)
            n.fb[r.cnt] = lnk.dl_data;
          else
            n.ovf = 1'b1;
          if (r.cnt != 8'hFF)
            n.cnt = r.cnt + 8'h01;
          // last byte must match running check
          n.crc_ok = (r.crc == lnk.dl_data);
          n.crc = crc8_upd(r.crc, lnk.dl_data);
          if (lnk.dl_last)
            n.st = D_EXEC;
        end
      end
      D_EXEC:
      begin
        n.status = {cmd, ST_OK};
        n.st = D_RESP;
        n.cnt = 8'h00;
        n.ovf = 1'b0;
        n.crc = CRC8_INIT;
        if (!ck[4] || ck[3:0] != r.fb[0][3:0])
          n.status = {cmd, ST_CMD};
        else
          case (cmd)
            CMD_WRITE_MEM:
              if (r.ovf || r.cnt < WR_MIN_LEN || ndata > maxd)
                n.status = {cmd, ST_LEN};
              else if (!r.crc_ok)
                n.status = {cmd, ST_CRC};
              else if (hit)
                n.status = {cmd, ST_LOCKED};
              else
              begin
                n.addr = waddr;
                n.nwr = ndata;
                n.idx = 8'h00;
                n.st = D_WRITE;
              end
            CMD_WRITE_PROT:
              if (r.cnt != PROT_LEN)
                n.status = {cmd, ST_LEN};
              else if (!r.crc_ok)
                n.status = {cmd, ST_CRC};
              else if (!pvalid)
                n.status = {cmd, ST_PARAM};
              else
              begin
                n.lock = r.lock | newlock;
                n.lock_we = 1'b1;
              end
            CMD_LEAVE_ENH:
              if (r.cnt != BARE_LEN)
                n.status = {cmd, ST_LEN};
              else
              begin
                n.enh = 1'b0;
                n.nv_enh_clr = 1'b1;
                n.pwr_sw_en = 1'b1;
                n.leave_pend = 1'b1;
              end
            CMD_REPEAT:
              if (r.cnt != BARE_LEN)
                n.status = {cmd, ST_LEN};
              else
                n.status = r.status;
            default:
              n.status = {cmd, ST_CMD};
          endcase
        n.ul_idx = 2'd0;
        n.ul_valid = (n.st == D_RESP);
        n.ul_data = PREAMBLE;
        n.ul_last = 1'b0;
      end
      D_WRITE:
      begin
        n.mem_we = 1'b1;
        n.mem_addr = r.addr + {8'h00, r.idx};
        n.mem_wdata = r.fb[r.idx + 8'(WR_DATA_POS)];
        n.idx = r.idx + 8'h01;
        if (n.idx == r.nwr)
        begin
          n.st = D_RESP;
          n.ul_idx = 2'd0;
          n.ul_valid = 1'b1;
          n.ul_data = PREAMBLE;
          n.ul_last = 1'b0;
        end
      end
      D_RESP:
      begin
        if (lnk.ul_ready)
        begin
          n.ul_idx = r.ul_idx + 2'd1;
          if (r.ul_idx == 2'd0)
            n.ul_data = r.status;
          else
            n.ul_data = crc8_upd(CRC8_INIT, r.status);
          n.ul_last = (r.ul_idx == 2'd1);
          if (r.ul_last)
          begin
            n.ul_valid = 1'b0;
            n.ul_last = 1'b0;
            n.st = r.leave_pend ? D_POR : D_RX;
          end
        end
      end
      D_POR:
        // held until the front end resets
        n.por_req = 1'b1;
      default: n.st = D_RX;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.st <= D_RX;
      r.crc <= CRC8_INIT;
      r.pwr_sw_en <= 1'b1;
    end
    else
      r <= n;
  end

endmodule : tmw_device

// *** tmw_host.sv ***
`timescale 1ns/1ps
module tmw_host
  import tmw_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Link to the transponder
  tmw_link_if.host lnk
);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_RECV = 2'b10
  } tmw_host_state_type;

  typedef struct packed {
    tmw_host_state_type st;
    logic [31:0] ctrl;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] param;
    logic [HOST_TX_MAX-1:0][7:0] tx;
    logic [3:0] ntx;
    logic [3:0] idx;
    logic dl_valid;
    logic [7:0] dl_data;
    logic dl_last;
    logic [1:0] rx_idx;
    logic [7:0] rx_pre;
    logic [7:0] rx_stat;
    logic rx_crc_ok;
    logic done;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } tmw_host_regs_type;

  tmw_host_regs_type r;
  tmw_host_regs_type n;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[8*i+:8] = strb[i] ? nw[8*i+:8] : old[8*i+:8];
  endfunction : merge

  assign awready = awvalid && wvalid && !r.bvalid;
  assign wready = awready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = !r.rvalid;
  assign rvalid = r.rvalid;
  assign rresp = r.rresp;
  assign rdata = r.rdata;
  assign lnk.dl_valid = r.dl_valid;
  assign lnk.dl_data = r.dl_data;
  assign lnk.dl_last = r.dl_last;
  assign lnk.ul_ready = (r.st == H_RECV);

  always_comb
  begin
    logic [3:0] cmd;
    logic [2:0] len;
    logic [3:0] k;
    logic [7:0] crc;
    logic start;
    logic [4:0] ck;
    cmd = r.ctrl[3:0];
    len = r.ctrl[CTRL_LEN_LSB+:3];
    k = 4'd1;
    crc = CRC8_INIT;
    start = 1'b0;
    ck = 5'h00;
    n = r;
    if (len == 3'd0)
      len = 3'd1;
    else if (len > 3'd4)
      len = 3'd4;
    if (r.bvalid && bready)
      n.bvalid = 1'b0;
    if (awready)
    begin
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (awaddr)
        OFS_CTRL:
        begin
          n.ctrl = merge(r.ctrl, wdata, wstrb) & 32'h0000070F;
          start = wstrb[3] && wdata[CTRL_START_BIT];
        end
        OFS_ADDR: n.addr = merge(r.addr, wdata, wstrb) & 32'h0000FFFF;
        OFS_WDATA: n.wdata = merge(r.wdata, wdata, wstrb);
        OFS_PARAM: n.param = merge(r.param, wdata, wstrb) & 32'h000000FF;
        OFS_STATUS: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (r.rvalid && rready)
      n.rvalid = 1'b0;
    if (arvalid && !r.rvalid)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h00000000;
      unique case (araddr)
        OFS_CTRL: n.rdata = r.ctrl;
        OFS_ADDR: n.rdata = r.addr;
        OFS_WDATA: n.rdata = r.wdata;
        OFS_PARAM: n.rdata = r.param;
        OFS_STATUS:
          n.rdata = {7'h00, r.rx_crc_ok, r.rx_pre, r.rx_stat,
            6'h00, r.done, (r.st != H_IDLE)};
        default: n.rresp = RESP_SLVERR;
      endcase
    end
    // Build the request frame from the fresh register values
    cmd = n.ctrl[3:0];
    len = n.ctrl[CTRL_LEN_LSB+:3];
    if (len == 3'd0)
      len = 3'd1;
    else if (len > 3'd4)
      len = 3'd4;
    n.tx = '0;
    ck = check_nibble(cmd);
    n.tx[0] = {cmd, ck[3:0]};
    if (cmd == CMD_WRITE_MEM)
    begin
      n.tx[1] = n.addr[15:8];
      n.tx[2] = n.addr[7:0];
      k = 4'd3;
      for (int j = 0; j < 4; j++)
        if (j < int'(len))
        begin
          n.tx[k] = n.wdata[8*j+:8];
          k = k + 4'd1;
        end
      n.tx[k] = n.param[7:0];
      k = k + 4'd1;
    end
    else if (cmd == CMD_WRITE_PROT)
    begin
      n.tx[1] = n.param[7:0];
      k = 4'd2;
    end
    for (int i = 0; i < HOST_TX_MAX; i++)
      if (i < int'(k))
        crc = crc8_upd(crc, n.tx[i]);
    if (k > 4'd1)
    begin
      n.tx[k] = crc;
      k = k + 4'd1;
    end
    unique case (r.st)
      H_IDLE:
        if (start)
        begin
          n.ntx = k;
          n.idx = 4'd0;
          n.dl_valid = 1'b1;
          n.dl_data = n.tx[0];
          n.dl_last = (k == 4'd1);
          n.done = 1'b0;
          n.rx_idx = 2'd0;
          n.st = H_SEND;
        end
        else
          n.tx = r.tx;
      H_SEND:
      begin
        n.tx = r.tx;
        if (lnk.dl_ready)
        begin
          n.idx = r.idx + 4'd1;
          n.dl_data = r.tx[n.idx];
          n.dl_last = (n.idx == r.ntx - 4'd1);
          if (r.dl_last)
          begin
            n.dl_valid = 1'b0;
            n.dl_last = 1'b0;
            n.st = H_RECV;
          end
        end
      end
      H_RECV:
      begin
        n.tx = r.tx;
        if (lnk.ul_valid)
        begin
          n.rx_idx = r.rx_idx + 2'd1;
          if (r.rx_idx == 2'd0)
            n.rx_pre = lnk.ul_data;
          else if (r.rx_idx == 2'd1)
            n.rx_stat = lnk.ul_data;
          else
            n.rx_crc_ok = (crc8_upd(CRC8_INIT, r.rx_stat) == lnk.ul_data);
          if (lnk.ul_last)
          begin
            n.done = 1'b1;
            n.st = H_IDLE;
          end
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.st <= H_IDLE;
    end
    else
      r <= n;
  end

endmodule : tmw_host

// *** tmw_link_chk.sv ***
`timescale 1ns/1ps
module tmw_link_chk
  import tmw_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Downlink
  input wire logic dl_valid,
  input wire logic dl_ready,
  input wire logic [7:0] dl_data,
  input wire logic dl_last,
  // Uplink
  input wire logic ul_valid,
  input wire logic ul_ready,
  input wire logic [7:0] ul_data,
  input wire logic ul_last
);
  logic [7:0] dl_cnt_r;
  logic [3:0] dl_code_r;
  logic [1:0] ul_cnt_r;
  logic [7:0] st_r;
  logic [3:0] cur_code;
  logic dl_take;
  logic ul_take;
  assign dl_take = dl_valid && dl_ready;
  assign ul_take = ul_valid && ul_ready;
  assign cur_code = (dl_cnt_r == 8'h00) ? dl_data[7:4] : dl_code_r;
  // Byte positions; st_r keeps the previous status for repeat
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dl_cnt_r <= 8'h00;
      dl_code_r <= 4'h0;
      ul_cnt_r <= 2'h0;
      st_r <= 8'h00;
    end
    else
    begin
      if (dl_take)
        dl_cnt_r <= dl_last ? 8'h00 : dl_cnt_r + 8'h01;
      if (dl_take && dl_cnt_r == 8'h00)
        dl_code_r <= dl_data[7:4];
      if (ul_take)
        ul_cnt_r <= ul_last ? 2'h0 : ul_cnt_r + 2'h1;
      if (ul_take && ul_cnt_r == 2'h1)
        st_r <= ul_data;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence last_taken;
    dl_take && dl_last;
  endsequence
  sequence resp_open;
    ul_valid && ul_cnt_r == 2'h0;
  endsequence
  chk_resp_follows: assert property (
    last_taken |=> !dl_ready throughout (##[0:300] resp_open))
    else $error("no response after request frame");
  chk_preamble_first: assert property (
    resp_open |-> ul_data == PREAMBLE)
    else $error("response does not open with preamble");
  chk_last_third: assert property (
    ul_valid |-> (ul_last == (ul_cnt_r == 2'h2)))
    else $error("frame end mark not on third byte");
  chk_ul_hold: assert property (
    ul_valid && !ul_ready |=> ul_valid && $stable(ul_data)
      && $stable(ul_last))
    else $error("uplink byte changed before taken");
  chk_dl_hold: assert property (
    dl_valid && !dl_ready |=> dl_valid && $stable(dl_data)
      && $stable(dl_last))
    else $error("downlink byte changed before taken");
  chk_status_echo: assert property (
    ul_valid && ul_cnt_r == 2'h1 && dl_code_r != CMD_REPEAT
      |-> ul_data[7:4] == dl_code_r)
    else $error("status does not echo command");
  chk_repeat_same: assert property (
    ul_valid && ul_cnt_r == 2'h1 && dl_code_r == CMD_REPEAT
      |-> ul_data == st_r)
    else $error("repeat changed the status byte");
  chk_code_nibble: assert property (
    dl_valid && dl_cnt_r == 8'h00 |->
      (dl_data[7:4] != CMD_WRITE_MEM || dl_data[3:0] == NIB_WRITE_MEM)
      && (dl_data[7:4] != CMD_WRITE_PROT || dl_data[3:0] == NIB_WRITE_PROT)
      && (dl_data[7:4] != CMD_LEAVE_ENH || dl_data[3:0] == NIB_LEAVE_ENH)
      && (dl_data[7:4] != CMD_REPEAT || dl_data[3:0] == NIB_REPEAT))
    else $error("command sent with wrong check nibble");
  chk_frame_len: assert property (
    last_taken |-> (cur_code == CMD_WRITE_MEM)
      ? (dl_cnt_r >= 8'h05 && dl_cnt_r <= 8'h08)
      : (cur_code == CMD_WRITE_PROT) ? (dl_cnt_r == 8'h02)
      : (cur_code == CMD_LEAVE_ENH || cur_code == CMD_REPEAT)
        ? (dl_cnt_r == 8'h00) : 1'b1)
    else $error("request frame has wrong length");
  // Leave-enhanced may park the device until reset
  chk_ready_return: assert property (
    ul_take && ul_last && dl_code_r != CMD_LEAVE_ENH
      |=> dl_ready && !ul_valid)
    else $error("device not ready after response");
endmodule : tmw_link_chk

// *** tmw_link_if.sv ***
`timescale 1ns/1ps
interface tmw_link_if;
  logic dl_valid;
  logic dl_ready;
  logic [7:0] dl_data;
  logic dl_last;
  logic ul_valid;
  logic ul_ready;
  logic [7:0] ul_data;
  logic ul_last;
  modport device (
    input dl_valid, dl_data, dl_last, ul_ready,
    output dl_ready, ul_valid, ul_data, ul_last
  );
  modport host (
    output dl_valid, dl_data, dl_last, ul_ready,
    input dl_ready, ul_valid, ul_data, ul_last
  );
endinterface : tmw_link_if

// *** tmw_pkg.sv ***
package tmw_pkg;
  // Command codes and their check nibbles
  localparam logic [3:0] CMD_WRITE_MEM = 4'h5;
  localparam logic [3:0] CMD_WRITE_PROT = 4'h6;
  localparam logic [3:0] CMD_LEAVE_ENH = 4'hA;
  localparam logic [3:0] CMD_REPEAT = 4'hE;
  localparam logic [3:0] NIB_WRITE_MEM = 4'hF;
  localparam logic [3:0] NIB_WRITE_PROT = 4'hA;
  localparam logic [3:0] NIB_LEAVE_ENH = 4'hD;
  localparam logic [3:0] NIB_REPEAT = 4'h1;
  // Response framing and check byte
  localparam logic [7:0] PREAMBLE = 8'hFE;
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [7:0] CRC8_INIT = 8'h00;
  // Encoded status codes, low nibble of the status byte
  localparam logic [3:0] ST_OK = 4'h0;
  localparam logic [3:0] ST_CRC = 4'h1;
  localparam logic [3:0] ST_LOCKED = 4'h2;
  localparam logic [3:0] ST_LEN = 4'h3;
  localparam logic [3:0] ST_CMD = 4'h4;
  localparam logic [3:0] ST_PARAM = 4'h5;
  // Data length limits and frame store
  localparam logic [7:0] MAX_DATA_NORMAL = 8'h04;
  localparam logic [7:0] MAX_DATA_ENH = 8'h80;
  localparam int FRAME_DEPTH = 136;
  localparam logic [7:0] WR_OVERHEAD = 8'h05;
  localparam logic [7:0] WR_MIN_LEN = 8'h06;
  localparam logic [7:0] PROT_LEN = 8'h03;
  localparam logic [7:0] BARE_LEN = 8'h01;
  localparam int WR_DATA_POS = 3;
  // Protected regions: index 0 is region one
  localparam logic [2:0][15:0] REGION_BASE =
    {16'h0810, 16'h0800, 16'h0780};
  localparam logic [2:0][15:0] REGION_LAST =
    {16'h081F, 16'h080F, 16'h07FF};
  localparam logic [1:0] LOCK_ON = 2'h3;
  localparam logic [1:0] LOCK_OFF = 2'h0;
  // Host register map (byte offsets) and fields
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_PARAM = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int CTRL_LEN_LSB = 8;
  localparam int CTRL_START_BIT = 31;
  localparam int STAT_CODE_LSB = 8;
  localparam int STAT_PRE_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int HOST_TX_MAX = 9;

  // Bit 4 set when the code is known
  function automatic logic [4:0] check_nibble(input logic [3:0] cmd);
    case (cmd)
      CMD_WRITE_MEM: check_nibble = {1'b1, NIB_WRITE_MEM};
      CMD_WRITE_PROT: check_nibble = {1'b1, NIB_WRITE_PROT};
      CMD_LEAVE_ENH: check_nibble = {1'b1, NIB_LEAVE_ENH};
      CMD_REPEAT: check_nibble = {1'b1, NIB_REPEAT};
      default: check_nibble = 5'h00;
    endcase
  endfunction : check_nibble

  // MSB-first CRC-8 over one byte
  function automatic logic [7:0] crc8_upd(input logic [7:0] crc,
                                          input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC8_POLY) : {c[6:0], 1'b0};
    crc8_upd = c;
  endfunction : crc8_upd
endpackage : tmw_pkg
